// ===== adc_config_register_bank.sv
// configuration register bank of the quad converter, reached by serial frames
// assumes sclk runs only while chip select is low, and that chip select stays high
// for at least four core clock cycles between frames
`timescale 1ns/1ps
module adc_config_register_bank (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic [15:0] conv_result,
  output logic serial_out_first,
  output logic channel_select,
  output logic sequencer_enable,
  output logic averaging_style,
  output logic [2:0] oversample_ratio,
  output logic out_check_enable,
  output logic second_pin_alert,
  output logic [3:0] lane_active,
  output logic extra_resolution,
  output logic reference_source_select,
  output logic power_down_select,
  output logic [1:0] output_lane_mode,
  output logic soft_reset_pulse,
  output logic hard_reset_pulse
);
  import cfg_bank_pkg::*;

  // ==========================================================
  // link side: capture and shift-out on serial_clk
  logic fresh;
  logic [COUNT_W-1:0] link_count;
  logic [LONG_BITS-1:0] link_shift;
  logic [FRAME_BITS-2:0] out_shift;
  logic [FRAME_BITS-1:0] out_word;
  logic [COUNT_W-1:0] next_link_count;

  // chip select high only presets a constant, so no capture data is lost
  always_ff @(posedge serial_clk or posedge chip_select_n or negedge arst_n) begin
    if (!arst_n) begin
      fresh <= 1'b1;
    end else if (chip_select_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // saturate so an overlong frame cannot wrap back to a legal length
  assign next_link_count = fresh ? COUNT_ONE :
      (link_count == COUNT_MAX) ? COUNT_MAX : link_count + COUNT_ONE;

  always_ff @(posedge serial_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_count <= '0;
      link_shift <= '0;
    end else begin
      link_count <= next_link_count;
      link_shift <= {link_shift[LONG_BITS-2:0], serial_in};
    end
  end

  // out_word is only changed by the core while chip select is high
  always_ff @(posedge serial_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out_first <= 1'b0;
      out_shift <= '0;
    end else if (fresh) begin
      serial_out_first <= out_word[FRAME_BITS-1];
      out_shift <= out_word[FRAME_BITS-2:0];
    end else begin
      serial_out_first <= out_shift[FRAME_BITS-2];
      out_shift <= {out_shift[FRAME_BITS-3:0], 1'b0};
    end
  end

  // ==========================================================
  // frame end detection in the core domain
  logic cs_sync;
  logic cs_prev;
  logic frame_end;

  level_sync2 #(.RESET_VALUE(1'b1)) cs_sync_u (
    .clk(core_clk),
    .arst_n(arst_n),
    .level_in(chip_select_n),
    .level_out(cs_sync)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_sync;
    end
  end

  assign frame_end = cs_sync & ~cs_prev;

  // ==========================================================
  // frame decode; capture registers are quiet once chip select is high
  logic is_long;
  logic is_short;
  logic [FRAME_BITS-1:0] cmd_word;
  logic [CHECK_BITS-1:0] rx_check;
  logic [CHECK_BITS-1:0] calc_check;
  logic is_write;
  logic [2:0] target_register_field;
  logic [11:0] payload;
  logic addr_one;
  logic addr_two;
  logic addr_valid;
  logic [11:0] setup_one;
  logic [1:0] lane_mode;
  logic check_in_enable;
  logic check_ok;
  logic needs_check;
  logic accept;
  logic do_write_one;
  logic do_write_two;
  logic do_read;
  logic soft_hit;
  logic hard_hit;

  assign is_long = link_count == LONG_COUNT;
  assign is_short = link_count == SHORT_COUNT;
  assign cmd_word = is_long ? link_shift[LONG_BITS-1:CHECK_BITS] : link_shift[FRAME_BITS-1:0];
  assign rx_check = link_shift[CHECK_BITS-1:0];
  assign is_write = cmd_word[WR_POS];
  assign target_register_field = cmd_word[ADDR_HI:ADDR_LO];
  assign payload = cmd_word[DATA_HI:0];
  assign addr_one = target_register_field == SETUP_ONE_ADDR;
  assign addr_two = target_register_field == OUT_CTRL_ADDR;
  assign addr_valid = addr_one | addr_two;
  assign check_in_enable = setup_one[CHECK_IN_POS];

  frame_check8 #(.POLY(CHECK_POLY), .INIT(CHECK_INIT)) check_u (
    .word(cmd_word),
    .check(calc_check)
  );

  assign check_ok = is_long & (calc_check == rx_check);
  // enabling needs a check, and once enabled every frame needs one
  assign needs_check = check_in_enable | (is_write & addr_one & payload[CHECK_IN_POS]);
  assign accept = frame_end & (is_short | is_long) & (~needs_check | check_ok);
  assign do_write_one = accept & is_write & addr_one;
  assign do_write_two = accept & is_write & addr_two;
  assign do_read = accept & ~is_write & addr_valid;
  assign soft_hit = do_write_two & (payload[RESET_HI:0] == SOFT_RESET_CODE);
  assign hard_hit = do_write_two & (payload[RESET_HI:0] == HARD_RESET_CODE);

  // ==========================================================
  // register storage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_one <= SETUP_ONE_RESET;
      lane_mode <= LANES_TWO;
    end else if (hard_hit) begin
      setup_one <= SETUP_ONE_RESET;
      lane_mode <= LANES_TWO;
    end else if (do_write_one) begin
      setup_one <= payload;
    end else if (do_write_two & ~soft_hit) begin
      // a soft reset frame refreshes only, so its lane bits are not taken
      lane_mode <= payload[LANE_HI:LANE_LO];
    end
  end

  // reserved bits and the reset field read zero; the field stores nothing
  logic [FRAME_BITS-1:0] read_one;
  logic [FRAME_BITS-1:0] read_two;
  assign read_one = {1'b0, SETUP_ONE_ADDR, setup_one};
  assign read_two = {1'b0, OUT_CTRL_ADDR, 2'b00, lane_mode, 8'h00};

  // any other frame, or a soft reset, returns to conversion readout
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_word <= '0;
    end else if (frame_end) begin
      if (do_read & addr_one) begin
        out_word <= read_one;
      end else if (do_read & addr_two) begin
        out_word <= read_two;
      end else begin
        out_word <= conv_result;
      end
    end
  end

  // ==========================================================
  // one-shot reset strobes and decoded controls
  logic [2:0] ratio_code;
  logic [2:0] next_ratio;
  logic [3:0] next_lanes;
  logic next_alert;

  assign ratio_code = setup_one[RATIO_HI:RATIO_LO];
  assign next_ratio = (ratio_code > RATIO_MAX_CODE) ? RATIO_OFF : ratio_code;
  assign next_lanes = (lane_mode == LANES_FOUR) ? LANE_MASK_FOUR :
      (lane_mode == LANES_TWO) ? LANE_MASK_TWO : LANE_MASK_ONE;
  assign next_alert = (lane_mode == LANES_ONE) & setup_one[ALERT_SEL_POS];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_pulse <= 1'b0;
      hard_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_hit;
      hard_reset_pulse <= hard_hit;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      oversample_ratio <= RATIO_OFF;
      lane_active <= LANE_MASK_TWO;
      second_pin_alert <= 1'b0;
      channel_select <= 1'b0;
      sequencer_enable <= 1'b0;
      averaging_style <= 1'b0;
      out_check_enable <= 1'b0;
      extra_resolution <= 1'b0;
      reference_source_select <= 1'b0;
      power_down_select <= 1'b0;
      output_lane_mode <= LANES_TWO;
    end else begin
      oversample_ratio <= next_ratio;
      lane_active <= next_lanes;
      second_pin_alert <= next_alert;
      channel_select <= setup_one[DATA_HI];
      sequencer_enable <= setup_one[DATA_HI-1];
      averaging_style <= setup_one[AVG_STYLE_POS];
      out_check_enable <= setup_one[CHECK_OUT_POS];
      extra_resolution <= setup_one[BOOST_POS];
      reference_source_select <= setup_one[REF_SEL_POS];
      power_down_select <= setup_one[POWER_POS];
      output_lane_mode <= lane_mode;
    end
  end

  // ==========================================================
  // checks
  default clocking core_cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // frame acceptance and register writes
  write_load_a: assert property (do_write_one & ~hard_hit |=> setup_one == $past(payload))
    else $error("setup write not loaded");
  write_two_a: assert property (do_write_two & ~soft_hit & ~hard_hit
      |=> lane_mode == $past(payload[LANE_HI:LANE_LO]))
    else $error("lane mode write not loaded");
  check_guard_a: assert property (frame_end & needs_check & ~check_ok
      |=> $stable(setup_one) && $stable(lane_mode))
    else $error("unchecked frame changed registers");
  enable_check_a: assert property ($rose(check_in_enable) |-> $past(check_ok))
    else $error("input check enabled without valid check");
  disable_check_a: assert property ($fell(check_in_enable)
      |-> $past(check_ok) || $past(hard_hit))
    else $error("input check disabled without valid check");
  enable_hold_a: assert property (frame_end & check_in_enable & ~check_ok
      |=> check_in_enable)
    else $error("input check dropped by an unchecked frame");

  // readback staging; the link only picks the word up at the next frame
  read_word_a: assert property (do_read & addr_two |=> out_word == read_two)
    else $error("read word not staged");
  read_one_a: assert property (do_read & addr_one |=> out_word == read_one)
    else $error("setup read word not staged");
  conv_pass_a: assert property (frame_end & ~do_read |=> out_word == $past(conv_result))
    else $error("conversion word not staged");

  // decoded controls lag the register by one cycle
  ratio_off_a: assert property (ratio_code > RATIO_MAX_CODE
      |=> oversample_ratio == RATIO_OFF)
    else $error("reserved ratio not disabled");
  ratio_pass_a: assert property (ratio_code <= RATIO_MAX_CODE
      |=> oversample_ratio == $past(ratio_code))
    else $error("ratio code not passed on");
  out_check_a: assert property (do_write_one |=> ##1
      out_check_enable == $past(payload[CHECK_OUT_POS], 2))
    else $error("output check bit not applied");
  boost_bit_a: assert property (do_write_one |=> ##1
      extra_resolution == $past(payload[BOOST_POS], 2))
    else $error("boost bit not applied");
  ref_select_a: assert property (do_write_one |=> ##1
      reference_source_select == $past(payload[REF_SEL_POS], 2))
    else $error("reference select not applied");
  power_bit_a: assert property (do_write_one |=> ##1
      power_down_select == $past(payload[POWER_POS], 2))
    else $error("power select not applied");
  alert_mode_a: assert property (second_pin_alert |-> $past(lane_mode) == LANES_ONE)
    else $error("alert select outside mode 01");
  alert_off_a: assert property (lane_mode != LANES_ONE |=> !second_pin_alert)
    else $error("alert shown outside mode 01");
  alert_on_a: assert property (lane_mode == LANES_ONE && setup_one[ALERT_SEL_POS]
      |=> second_pin_alert)
    else $error("alert select not applied");
  lane_two_a: assert property (lane_mode == LANES_TWO |=> lane_active == LANE_MASK_TWO)
    else $error("two lane mask wrong");
  four_lane_a: assert property (lane_mode == LANES_FOUR ##1 lane_mode == LANES_FOUR
      |-> lane_active == LANE_MASK_FOUR)
    else $error("four lane mask wrong");
  lane_one_a: assert property ((lane_mode == LANES_ONE) | (lane_mode == LANES_ONE_ALT)
      |=> lane_active == LANE_MASK_ONE)
    else $error("one lane mask wrong");

  // reset field strobes
  soft_pulse_a: assert property (soft_hit |=> soft_reset_pulse)
    else $error("soft reset strobe missing");
  soft_keep_a: assert property (soft_reset_pulse
      |-> $stable(setup_one) && $stable(lane_mode))
    else $error("soft reset altered registers");
  hard_pulse_a: assert property (hard_hit |=> hard_reset_pulse)
    else $error("hard reset strobe missing");
  hard_default_a: assert property (hard_reset_pulse
      |-> setup_one == SETUP_ONE_RESET && lane_mode == LANES_TWO)
    else $error("hard reset left registers");
  other_code_a: assert property (do_write_two & ~soft_hit & ~hard_hit
      |=> !(soft_reset_pulse | hard_reset_pulse))
    else $error("odd reset code fired a strobe");
  reset_once_a: assert property (soft_reset_pulse | hard_reset_pulse
      |=> !(soft_reset_pulse | hard_reset_pulse))
    else $error("reset strobe repeated");
endmodule

// ===== adc_config_register_bank_tb.sv
// self-checking bench for the configuration register bank
// assumes the host model owns the link pins; frames settle within its idle gap
`timescale 1ns/1ps
`define chk(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module adc_config_register_bank_tb;
  import cfg_bank_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] conv_result = 16'h5A3C;
  logic serial_clk, chip_select_n, serial_in, serial_out_first;
  logic channel_select, sequencer_enable, averaging_style, out_check_enable;
  logic second_pin_alert, extra_resolution, reference_source_select, power_down_select;
  logic soft_reset_pulse, hard_reset_pulse;
  logic [2:0] oversample_ratio;
  logic [3:0] lane_active;
  logic [1:0] output_lane_mode;
  int checks = 0;
  int n_mismatch = 0;
  int n_soft = 0;
  int n_hard = 0;
  always #5 core_clk = ~core_clk;
  // ==========================================================
  // design and host
  adc_config_register_bank uut (.core_clk(core_clk), .arst_n(arst_n),
    .serial_clk(serial_clk), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .conv_result(conv_result), .serial_out_first(serial_out_first),
    .channel_select(channel_select), .sequencer_enable(sequencer_enable),
    .averaging_style(averaging_style), .oversample_ratio(oversample_ratio),
    .out_check_enable(out_check_enable), .second_pin_alert(second_pin_alert),
    .lane_active(lane_active), .extra_resolution(extra_resolution),
    .reference_source_select(reference_source_select),
    .power_down_select(power_down_select), .output_lane_mode(output_lane_mode),
    .soft_reset_pulse(soft_reset_pulse), .hard_reset_pulse(hard_reset_pulse));
  host_serial_model host (.serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out_first(serial_out_first));
  // pulses are one core cycle wide, so count them rather than sample
  always @(posedge core_clk) begin
    if (soft_reset_pulse === 1'b1) n_soft++;
    if (hard_reset_pulse === 1'b1) n_hard++;
  end
  // ==========================================================
  // access tasks
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // m: 0 plain frame, 1 good check, 2 corrupted check
  task automatic xfer(input logic [15:0] w, input int m, output logic [15:0] rx);
    if (m == 0) host.send({8'h00, w}, 16, rx);
    else host.send({w, crc8(w) ^ ((m == 2) ? 8'hFF : 8'h00)}, 24, rx);
  endtask
  task automatic rd(input logic [2:0] a, input int m, output logic [15:0] v);
    logic [15:0] rx;
    xfer({1'b0, a, 12'h000}, m, rx);
    xfer(16'h0000, m, v);
  endtask
  task automatic results;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    results;
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] v, w;
    logic [2:0] r;
    logic [1:0] lm;
    logic [3:0] ex;
    logic b;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    `chk(lane_active, LANE_MASK_TWO)
    `chk(power_down_select, 1'b0)
    // every ratio code, other setup bits except input check enable toggled alongside
    for (int c = 0; c < 8; c++) begin
      r = c[2:0];
      b = r[0];
      w = {4'h9, {3{~b}}, r, 1'b0, b, ~b, b, b, b};
      xfer(w, 0, v);
      `chk(oversample_ratio, (r > RATIO_MAX_CODE) ? RATIO_OFF : r)
      `chk(channel_select, ~b)
      `chk(sequencer_enable, ~b)
      `chk(averaging_style, ~b)
      `chk(out_check_enable, b)
      `chk(extra_resolution, b)
      `chk(reference_source_select, b)
      `chk(power_down_select, b)
      rd(SETUP_ONE_ADDR, 0, v);
      `chk(v, {4'h1, w[11:0]})
    end
    // lane modes with alert select set; reserved bits written high
    xfer(16'h9008, 0, v);
    for (int m = 0; m < 4; m++) begin
      lm = m[1:0];
      xfer({4'hA, 2'b11, lm, 8'h00}, 0, v);
      `chk(output_lane_mode, lm)
      ex = (lm == 2'h2) ? LANE_MASK_FOUR : (lm == 2'h0) ? LANE_MASK_TWO : LANE_MASK_ONE;
      `chk(lane_active, ex)
      `chk(second_pin_alert, lm == 2'h1)
      rd(OUT_CTRL_ADDR, 0, v);
      `chk(v, {4'h2, 2'b00, lm, 8'h00})
    end
    xfer(16'hA100, 0, v);
    xfer(16'h9000, 0, v);
    `chk(second_pin_alert, 1'b0)
    // without a pending read the conversion word comes out
    @(negedge core_clk) conv_result = 16'hC3A5;
    xfer(16'h0000, 0, v);
    xfer(16'h0000, 0, v);
    `chk(v, 16'hC3A5)
    // soft reset keeps registers and fires once
    xfer(16'h9047, 0, v);
    xfer({8'hA0, SOFT_RESET_CODE}, 0, v);
    `chk(n_soft, 1)
    `chk(oversample_ratio, 3'h1)
    `chk(power_down_select, 1'b1)
    `chk(output_lane_mode, 2'h1)
    for (int i = 0; i < 3; i++) xfer({8'hA0, 8'h55 + 8'(i) * 8'h3D}, 0, v);
    `chk(n_soft, 1)
    `chk(n_hard, 0)
    `chk(power_down_select, 1'b1)
    xfer({8'hA1, HARD_RESET_CODE}, 0, v);
    `chk(n_hard, 1)
    `chk(oversample_ratio, 3'h0)
    `chk(power_down_select, 1'b0)
    `chk(lane_active, LANE_MASK_TWO)
    rd(OUT_CTRL_ADDR, 0, v);
    `chk(v, 16'h2000)
    // input check enable and disable both need a good check
    xfer(16'h9021, 0, v);
    `chk(power_down_select, 1'b0)
    xfer(16'h9021, 1, v);
    `chk(power_down_select, 1'b1)
    rd(SETUP_ONE_ADDR, 1, v);
    `chk(v, 16'h1021)
    xfer(16'h9000, 0, v);
    `chk(power_down_select, 1'b1)
    xfer(16'h9000, 2, v);
    `chk(power_down_select, 1'b1)
    xfer(16'h9000, 1, v);
    `chk(power_down_select, 1'b0)
    results;
  end
endmodule

// ===== cfg_bank_pkg.sv
// constants shared by the configuration register bank of the quad converter
// assumes a 16-bit host frame with an optional trailing 8-bit frame check
//
// Function
// - write flag loads twelve payload bits
// - read request shifts register out next access
// - ratio codes 1-5 active, 6-7 disabled
// - enabling input check needs valid check
// - bad check discards a frame that needs a check, registers unchanged
// - disabling input check needs valid check
// - output check bit gates output check
// - alert select honoured only in mode 01
// - alert select moves second pin to alert
// - boost bit adds two result bits
// - reference bit picks internal or external
// - power bit selects shutdown
// - top four bits read register address
// - mode 00 uses first two lanes
// - mode 10 uses all four lanes
// - modes 01 and 11 use first lane
// - code 3C soft reset, registers kept
// - code FF restores register defaults
// - other reset codes do nothing
package cfg_bank_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CHECK_BITS = 8;
  localparam int LONG_BITS = FRAME_BITS + CHECK_BITS;
  localparam int COUNT_W = 5;
  localparam logic [COUNT_W-1:0] SHORT_COUNT = 5'h10;
  localparam logic [COUNT_W-1:0] LONG_COUNT = 5'h18;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 5'h01;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 5'h1F;
  localparam int WR_POS = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 12;
  localparam int DATA_HI = 11;
  localparam logic [2:0] SETUP_ONE_ADDR = 3'h1;
  localparam logic [2:0] OUT_CTRL_ADDR = 3'h2;
  localparam logic [11:0] SETUP_ONE_RESET = 12'h000;
  localparam int AVG_STYLE_POS = 9;
  localparam int RATIO_HI = 8;
  localparam int RATIO_LO = 6;
  localparam int CHECK_IN_POS = 5;
  localparam int CHECK_OUT_POS = 4;
  localparam int ALERT_SEL_POS = 3;
  localparam int BOOST_POS = 2;
  localparam int REF_SEL_POS = 1;
  localparam int POWER_POS = 0;
  localparam int LANE_HI = 9;
  localparam int LANE_LO = 8;
  localparam int RESET_HI = 7;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h3C;
  localparam logic [7:0] HARD_RESET_CODE = 8'hFF;
  localparam logic [2:0] RATIO_MAX_CODE = 3'h5;
  localparam logic [2:0] RATIO_OFF = 3'h0;
  localparam logic [7:0] CHECK_POLY = 8'h07;
  localparam logic [7:0] CHECK_INIT = 8'h00;
  typedef enum logic [1:0] {
    LANES_TWO = 2'h0,
    LANES_ONE = 2'h1,
    LANES_FOUR = 2'h2,
    LANES_ONE_ALT = 2'h3
  } lane_mode_t;
  localparam logic [3:0] LANE_MASK_ONE = 4'h1;
  localparam logic [3:0] LANE_MASK_TWO = 4'h3;
  localparam logic [3:0] LANE_MASK_FOUR = 4'hF;
endpackage

// ===== frame_check8.sv
// frame check generator over one 16-bit command word
// assumes the word is stable while the result is read; purely combinational
`timescale 1ns/1ps
module frame_check8 #(
  parameter logic [7:0] POLY = 8'h07,
  parameter logic [7:0] INIT = 8'h00
) (
  input wire logic [15:0] word,
  output logic [7:0] check
);
  // msb first, no reflection
  always_comb begin
    logic [7:0] acc;
    acc = INIT;
    for (int i = 15; i >= 0; i--) begin
      if (acc[7] ^ word[i]) begin
        acc = {acc[6:0], 1'b0} ^ POLY;
      end else begin
        acc = {acc[6:0], 1'b0};
      end
    end
    check = acc;
  end
endmodule

// ===== host_serial_model.sv
// host serial port model that sends command frames to the register bank
// assumes a 48 ns link clock that stands low outside frames
`timescale 1ns/1ps
module host_serial_model (
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out_first
);
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // ==========================================================
  // frame transfer, msb first; n is 16 or 24 bits
  task automatic send(input logic [23:0] bits, input int n, output logic [15:0] rx);
    int k;
    rx = 16'h0000;
    // odd start offset keeps the link phase unrelated to the core clock
    #7.3;
    chip_select_n = 1'b0;
    for (k = n - 1; k >= 0; k--) begin
      serial_in = bits[k];
      #24 serial_clk = 1'b1;
      #24 serial_clk = 1'b0;
      if (k >= n - 16) rx = {rx[14:0], serial_out_first};
    end
    #24 chip_select_n = 1'b1;
    // released line shows the inverse so a stale bit cannot pass
    serial_in = ~serial_in;
    #200;
  endtask
endmodule

// ===== level_sync2.sv
// two-stage synchroniser for a single level
// assumes the input changes no faster than the destination clock can follow
`timescale 1ns/1ps
module level_sync2 #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic level_in,
  output logic level_out
);
  logic stage_one;
  // stage_one feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_one <= RESET_VALUE;
      level_out <= RESET_VALUE;
    end else begin
      stage_one <= level_in;
      level_out <= stage_one;
    end
  end
endmodule
